// ===== rtl/scdma_pkg.sv
// Purpose: Shared constants of the serial channel DMA handshake.
// Assumes: One 50 MHz clock, asynchronous active-low reset.
// Notes:   Widths and depths are fixed; nothing here is tunable.

package scdma_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CH = 8;
   localparam int BYTE_W = 8;
   localparam int BUS_W = 16;
   localparam int CNT_W = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int LVL_W = 6;
   localparam int SEL_W = 3;
   localparam int SYNC_W = NUM_CH + 4 + BUS_W;

   // ----------------------------------------------------------------
   // Block and access figures
   // ----------------------------------------------------------------
   localparam logic [LVL_W-1:0] BLOCK_BYTES = 6'h20;
   localparam logic [LVL_W-1:0] LVL_ZERO = 6'h00;
   localparam logic [LVL_W-1:0] ONE_BYTE = 6'h01;
   localparam logic [LVL_W-1:0] TWO_BYTES = 6'h02;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   // ----------------------------------------------------------------
   // Positions inside the synchroniser vector and the bus word
   // ----------------------------------------------------------------
   localparam int SY_ACK = 0;
   localparam int SY_WR = NUM_CH;
   localparam int SY_RD = NUM_CH + 1;
   localparam int SY_A0 = NUM_CH + 2;
   localparam int SY_BLE = NUM_CH + 3;
   localparam int SY_DATA = NUM_CH + 4;
   localparam int LO_BYTE = 0;
   localparam int HI_BYTE = BYTE_W;

endpackage : scdma_pkg

// ===== rtl/scdma_top.sv
// Function
// - Transmit request raised only while the transmit FIFO has room for the whole next block.
// - Transmit data requested in 32-byte blocks plus remainder, until count done.
// - Transmit request drops as the last write of a block starts.
// - Receive request raised only while receive FIFO holds a whole 32-byte block.
// - Receive request drops right after the last read of a block begins.
// - Acknowledge plus strobe selects channel FIFOs; upper address ignored.
// - Address bit zero and byte-lane enable choose byte or word access.
//
// Purpose: DMA request and acknowledge handling for eight serial channels.
// Assumes: Bus strobes and acknowledges are asynchronous and held for
//          several clocks; at most one acknowledge is low at a time.
// Notes:   A word access moves two bytes, low byte first.

`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Byte FIFO with registered flags
// ------------------------------------------------------------------
module scdma_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int LW = 6
) (
   input wire logic clock,               // System clock.
   input wire logic resetn,              // Asynchronous reset, active low.
   input wire logic in_valid,            // Write request.
   output logic in_ready,                // Room for one more word.
   input wire logic [WIDTH-1:0] in_data, // Write data.
   output logic out_valid,               // Head word present.
   input wire logic out_ready,           // Consumer takes the head.
   output logic [WIDTH-1:0] out_data,    // Head word.
   output logic [LW-1:0] level           // Words held.
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [LW-2:0] wr_ptr_reg;
   logic [LW-2:0] rd_ptr_reg;
   logic [LW-1:0] level_reg;
   logic [LW-1:0] level_next;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg];
   assign level = level_reg;
   assign level_next = level_reg + LW'(push) - LW'(pop);

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (LW-1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (LW-1)'(pop);
         level_reg <= level_next;
         in_ready <= level_next != LW'(DEPTH);
         out_valid <= level_next != '0;
      end
   end
endmodule : scdma_fifo

// ------------------------------------------------------------------
// Channel handshake top
// ------------------------------------------------------------------
module scdma_top (
   input wire logic clock,                           // 50 MHz clock.
   input wire logic resetn,                          // Async reset, low.
   input wire logic wr_n,                            // Bus write strobe.
   input wire logic rd_n,                            // Bus read strobe.
   input wire logic addr0,                           // Address bit zero.
   input wire logic byte_lane_enable_n,              // High-byte enable.
   input wire logic [scdma_pkg::BUS_W-1:0] data_in,  // Bus data in.
   output logic [scdma_pkg::BUS_W-1:0] data_out,     // Bus data out.
   output logic data_oe,                             // Bus data drive.
   input wire logic [scdma_pkg::NUM_CH-1:0] dma_acknowledge_n, // Acks.
   output logic [scdma_pkg::NUM_CH-1:0] tx_dma_request, // Tx requests.
   output logic [scdma_pkg::NUM_CH-1:0] rx_dma_request, // Rx requests.
   input wire logic [scdma_pkg::NUM_CH-1:0][scdma_pkg::BYTE_W-1:0]
      tx_byte_count_high,                            // Count high byte.
   input wire logic [scdma_pkg::NUM_CH-1:0][scdma_pkg::BYTE_W-1:0]
      tx_byte_count_low,                             // Count low byte.
   input wire logic [scdma_pkg::NUM_CH-1:0] tx_count_load, // Load count.
   output logic [scdma_pkg::NUM_CH-1:0][scdma_pkg::BYTE_W-1:0]
      tx_data,                                       // Byte to serial.
   output logic [scdma_pkg::NUM_CH-1:0] tx_valid,    // Tx byte valid.
   input wire logic [scdma_pkg::NUM_CH-1:0] tx_ready, // Serial takes byte.
   input wire logic [scdma_pkg::NUM_CH-1:0][scdma_pkg::BYTE_W-1:0]
      rx_data,                                       // Byte from serial.
   input wire logic [scdma_pkg::NUM_CH-1:0] rx_valid, // Rx byte valid.
   output logic [scdma_pkg::NUM_CH-1:0] rx_ready     // Rx FIFO has room.
);
   import scdma_pkg::*;

   function automatic logic [LVL_W-1:0] access_bytes(input logic word);
      access_bytes = word ? TWO_BYTES : ONE_BYTE;
   endfunction : access_bytes

   function automatic logic [SEL_W-1:0] ack_channel(
      input logic [NUM_CH-1:0] ack_n);
      ack_channel = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (!ack_n[i]) begin
            ack_channel = SEL_W'(i);
         end
      end
   endfunction : ack_channel

   // ----------------------------------------------------------------
   // Pin synchronisers and strobe edges
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic wr_old_reg;
   logic rd_old_reg;
   logic [NUM_CH-1:0] ack;
   logic any_ack;
   logic [SEL_W-1:0] sel;
   logic word;
   logic wr_start;
   logic rd_start;
   logic [BUS_W-1:0] bus_data;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
         wr_old_reg <= 1'b1;
         rd_old_reg <= 1'b1;
      end else begin
         sync1_reg <= {data_in, byte_lane_enable_n, addr0, rd_n, wr_n,
                       dma_acknowledge_n};
         sync2_reg <= sync1_reg;
         wr_old_reg <= sync2_reg[SY_WR];
         rd_old_reg <= sync2_reg[SY_RD];
      end
   end

   // Only acknowledge and strobes select the FIFOs; no upper address.
   assign ack = ~sync2_reg[SY_ACK +: NUM_CH];
   assign any_ack = |ack;
   assign sel = ack_channel(sync2_reg[SY_ACK +: NUM_CH]);
   assign word = !sync2_reg[SY_A0] && !sync2_reg[SY_BLE];
   assign bus_data = sync2_reg[SY_DATA +: BUS_W];
   assign wr_start = any_ack && wr_old_reg && !sync2_reg[SY_WR];
   assign rd_start = any_ack && rd_old_reg && !sync2_reg[SY_RD];

   // ----------------------------------------------------------------
   // Per-channel request engines
   // ----------------------------------------------------------------
   logic [NUM_CH-1:0][BYTE_W-1:0] rx_head;
   logic [NUM_CH-1:0] rd_hi_pend;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         logic [CNT_W-1:0] remain_reg;
         logic [LVL_W-1:0] tx_left_reg;
         logic [LVL_W-1:0] rx_left_reg;
         logic wr_hi_pend_reg;
         logic rd_hi_pend_reg;
         logic [LVL_W-1:0] tx_level;
         logic [LVL_W-1:0] rx_level;
         logic [LVL_W-1:0] tx_free;
         logic [LVL_W-1:0] tx_block;
         logic [LVL_W-1:0] n_bytes;
         logic tx_in_ready;
         logic tx_push;
         logic [BYTE_W-1:0] tx_byte;
         logic tx_fifo_valid;
         logic [BYTE_W-1:0] tx_fifo_data;
         logic tx_fifo_take;
         logic rx_pop;
         logic my_wr;
         logic my_rd;

         assign my_wr = wr_start && sel == SEL_W'(ch);
         assign my_rd = rd_start && sel == SEL_W'(ch);
         assign n_bytes = access_bytes(word);
         assign tx_free = LVL_W'(FIFO_DEPTH) - tx_level;
         assign tx_block = (remain_reg < CNT_W'(BLOCK_BYTES)) ?
                           remain_reg[LVL_W-1:0] : BLOCK_BYTES;
         assign tx_push = my_wr || wr_hi_pend_reg;
         assign tx_byte = wr_hi_pend_reg ? bus_data[HI_BYTE +: BYTE_W] :
                          (!word && sync2_reg[SY_A0]) ?
                          bus_data[HI_BYTE +: BYTE_W] :
                          bus_data[LO_BYTE +: BYTE_W];
         assign rx_pop = my_rd || rd_hi_pend_reg;
         assign rd_hi_pend[ch] = rd_hi_pend_reg;
         assign tx_fifo_take = !tx_valid[ch] || tx_ready[ch];

         // Transmit side: count, blocks and request.
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               remain_reg <= CNT_ZERO;
               tx_left_reg <= LVL_ZERO;
               tx_dma_request[ch] <= 1'b0;
               wr_hi_pend_reg <= 1'b0;
            end else begin
               wr_hi_pend_reg <= my_wr && word;
               if (tx_count_load[ch]) begin
                  remain_reg <= {tx_byte_count_high[ch],
                                 tx_byte_count_low[ch]};
                  tx_left_reg <= LVL_ZERO;
                  tx_dma_request[ch] <= 1'b0;
               end else if (my_wr) begin
                  remain_reg <= (remain_reg > CNT_W'(n_bytes)) ?
                                remain_reg - CNT_W'(n_bytes) : CNT_ZERO;
                  tx_left_reg <= (tx_left_reg > n_bytes) ?
                                 tx_left_reg - n_bytes : LVL_ZERO;
                  if (n_bytes >= tx_left_reg) begin
                     tx_dma_request[ch] <= 1'b0;
                  end
               end else if (tx_left_reg == LVL_ZERO &&
                            remain_reg != CNT_ZERO &&
                            tx_free >= tx_block) begin
                  // Wait for room for the whole block so it never stalls.
                  tx_left_reg <= tx_block;
                  tx_dma_request[ch] <= 1'b1;
               end
            end
         end

         // Receive side: raise only for a full block of bytes.
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               rx_left_reg <= LVL_ZERO;
               rx_dma_request[ch] <= 1'b0;
               rd_hi_pend_reg <= 1'b0;
            end else begin
               rd_hi_pend_reg <= my_rd && word;
               if (my_rd) begin
                  rx_left_reg <= (rx_left_reg > n_bytes) ?
                                 rx_left_reg - n_bytes : LVL_ZERO;
                  if (n_bytes >= rx_left_reg) begin
                     rx_dma_request[ch] <= 1'b0;
                  end
               end else if (rx_left_reg == LVL_ZERO &&
                            rx_level >= BLOCK_BYTES) begin
                  rx_left_reg <= BLOCK_BYTES;
                  rx_dma_request[ch] <= 1'b1;
               end
            end
         end

         // Output stage toward the serial transmitter.
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               tx_valid[ch] <= 1'b0;
               tx_data[ch] <= '0;
            end else if (tx_fifo_take) begin
               tx_valid[ch] <= tx_fifo_valid;
               tx_data[ch] <= tx_fifo_data;
            end
         end

         scdma_fifo #(
            .WIDTH(BYTE_W),
            .DEPTH(FIFO_DEPTH),
            .LW(LVL_W)
         ) u_tx_fifo (
            .clock(clock),
            .resetn(resetn),
            .in_valid(tx_push),
            .in_ready(tx_in_ready),
            .in_data(tx_byte),
            .out_valid(tx_fifo_valid),
            .out_ready(tx_fifo_take),
            .out_data(tx_fifo_data),
            .level(tx_level)
         );

         scdma_fifo #(
            .WIDTH(BYTE_W),
            .DEPTH(FIFO_DEPTH),
            .LW(LVL_W)
         ) u_rx_fifo (
            .clock(clock),
            .resetn(resetn),
            .in_valid(rx_valid[ch]),
            .in_ready(rx_ready[ch]),
            .in_data(rx_data[ch]),
            .out_valid(),
            .out_ready(rx_pop),
            .out_data(rx_head[ch]),
            .level(rx_level)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data onto the bus
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         data_out <= '0;
         data_oe <= 1'b0;
      end else begin
         data_oe <= any_ack && !sync2_reg[SY_RD];
         if (rd_start) begin
            if (!word && sync2_reg[SY_A0]) begin
               data_out[HI_BYTE +: BYTE_W] <= rx_head[sel];
            end else begin
               data_out[LO_BYTE +: BYTE_W] <= rx_head[sel];
            end
         end else if (rd_hi_pend[sel]) begin
            data_out[HI_BYTE +: BYTE_W] <= rx_head[sel];
         end
      end
   end

endmodule : scdma_top

`default_nettype wire

// ===== verif/scdma_chk.sv
// Purpose: Port-level timing checks of the channel DMA handshake.
// Assumes: Bus inputs are held at least four clocks.
// Notes:   Bound to the top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module scdma_chk (
   input wire logic clock, // Clock.
   input wire logic resetn, // Reset, low.
   input wire logic wr_n, // Write strobe.
   input wire logic rd_n, // Read strobe.
   input wire logic [scdma_pkg::BUS_W-1:0] data_out, // Read data.
   input wire logic data_oe, // Data drive.
   input wire logic [scdma_pkg::NUM_CH-1:0] dma_acknowledge_n, // Acks.
   input wire logic [scdma_pkg::NUM_CH-1:0] tx_dma_request, // Tx req.
   input wire logic [scdma_pkg::NUM_CH-1:0] rx_dma_request, // Rx req.
   input wire logic [scdma_pkg::NUM_CH-1:0] tx_valid, // Tx valid.
   input wire logic [scdma_pkg::NUM_CH-1:0] tx_ready // Tx ready.
);
   import scdma_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence s_rd_idle;
      rd_n [*4];
   endsequence
   sequence s_no_ack;
      (&dma_acknowledge_n) [*4];
   endsequence
   // A request may only fall while its own channel is acknowledged.
   chk_tx_drop_write: assert property (
      |($past(tx_dma_request) & ~tx_dma_request) |-> !$past(wr_n, 2) &&
      (($past(tx_dma_request) & ~tx_dma_request
      & $past(dma_acknowledge_n, 2)) == 8'h00))
      else $error("tx request fell without a write");
   chk_rx_drop_read: assert property (
      |($past(rx_dma_request) & ~rx_dma_request) |-> !$past(rd_n, 2) &&
      (($past(rx_dma_request) & ~rx_dma_request
      & $past(dma_acknowledge_n, 2)) == 8'h00))
      else $error("rx request fell without a read");
   chk_oe_cause: assert property (
      $rose(data_oe) |-> !$past(rd_n, 2) && !$past(&dma_acknowledge_n, 2))
      else $error("data drive without acknowledged read");
   chk_oe_release: assert property (
      s_rd_idle |=> !data_oe)
      else $error("data drive outlives the read");
   chk_no_ack_quiet: assert property (
      s_no_ack |=> !data_oe)
      else $error("data drive with no acknowledge");
   chk_dout_holds: assert property (
      s_rd_idle |=> $stable(data_out))
      else $error("read data moved without a read");
   chk_wr_no_drive: assert property (
      (!wr_n) [*4] |-> !data_oe)
      else $error("data drive during a write");
   chk_tx_hold: assert property (
      ($past(tx_valid) & ~$past(tx_ready) & ~tx_valid) == 8'h00)
      else $error("tx byte withdrawn before taken");
endmodule : scdma_chk
bind scdma_top scdma_chk chk_u (.clock, .resetn, .wr_n, .rd_n, .data_out,
   .data_oe, .dma_acknowledge_n, .tx_dma_request, .rx_dma_request,
   .tx_valid, .tx_ready);
`default_nettype wire

// ===== verif/scdma_dma_model.sv
// Purpose: Behavioural DMA controller driving the system bus.
// Assumes: Called just after a rising edge.
// Notes:   Hold sets prompt or slow cycles.
`timescale 1ns/100ps
`default_nettype none
module scdma_dma_model (
   input wire logic clock, // System clock.
   input wire logic [scdma_pkg::BUS_W-1:0] data_out, // Read data.
   output logic wr_n, // Write strobe.
   output logic rd_n, // Read strobe.
   output logic addr0, // Address bit zero.
   output logic byte_lane_enable_n, // High-byte enable.
   output logic [scdma_pkg::BUS_W-1:0] data_in, // Write data.
   output logic [scdma_pkg::NUM_CH-1:0] dma_acknowledge_n // Acks.
);
   import scdma_pkg::*;
   initial begin
      wr_n = 1'b1;
      rd_n = 1'b1;
      addr0 = 1'b0;
      byte_lane_enable_n = 1'b1;
      data_in = 16'h0000;
      dma_acknowledge_n = '1;
   end
   // A negative channel leaves every acknowledge high.
   task automatic access(input logic rd, input int ch, input logic a0,
      input logic ble, input logic [BUS_W-1:0] wdat, input int hold,
      output logic [BUS_W-1:0] rdat);
      @(posedge clock);
      #1;
      if (ch >= 0) dma_acknowledge_n[ch] = 1'b0;
      addr0 = a0;
      byte_lane_enable_n = ble;
      data_in = wdat;
      rd_n = !rd;
      wr_n = rd;
      repeat (hold) @(posedge clock);
      #1;
      rdat = data_out;
      rd_n = 1'b1;
      wr_n = 1'b1;
      dma_acknowledge_n = '1;
      // A released bus must not look like a held one.
      data_in = ~wdat;
      repeat (4) @(posedge clock);
      #1;
   endtask : access
endmodule : scdma_dma_model
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench of the channel DMA handshake.
// Assumes: The partner model plays the DMA controller.
// Notes:   Inputs move 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import scdma_pkg::*;
   logic clock, resetn, wr_n, rd_n, addr0, byte_lane_enable_n, data_oe;
   logic [BUS_W-1:0] data_in, data_out, rd_q;
   logic [NUM_CH-1:0] dma_acknowledge_n, tx_dma_request, rx_dma_request;
   logic [NUM_CH-1:0] tx_count_load, tx_valid, tx_ready, rx_valid, rx_ready;
   logic [NUM_CH-1:0][BYTE_W-1:0] tx_byte_count_high, tx_byte_count_low;
   logic [NUM_CH-1:0][BYTE_W-1:0] tx_data, rx_data;
   int n_mismatch, n_tests;
   scdma_top dut_u (.clock, .resetn, .wr_n, .rd_n, .addr0,
      .byte_lane_enable_n, .data_in, .data_out, .data_oe,
      .dma_acknowledge_n, .tx_dma_request, .rx_dma_request,
      .tx_byte_count_high, .tx_byte_count_low, .tx_count_load, .tx_data,
      .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);
   scdma_dma_model dma_u (.clock, .data_out, .wr_n, .rd_n, .addr0,
      .byte_lane_enable_n, .data_in, .dma_acknowledge_n);
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_req(input bit tx, input int ch);
      int w;
      for (w = 0; w < 300; w++) begin
         @(negedge clock);
         if ((tx ? tx_dma_request[ch] : rx_dma_request[ch]) === 1'b1) return;
      end
      check("req wait", 16'h0000, 16'h0001);
      give_verdict();
   endtask : wait_req
   task automatic drain(input int n, input logic [7:0] base);
      int j, w;
      @(posedge clock);
      #1;
      tx_ready[2] = 1'b1;
      for (j = 0; j < n; j++) begin
         for (w = 0; w < 50 && tx_valid[2] !== 1'b1; w++) @(negedge clock);
         if (tx_valid[2] !== 1'b1) begin
            check("tx valid", tx_valid[2], 1'b1);
            give_verdict();
         end
         check("tx byte", tx_data[2], base + j[7:0]);
         @(posedge clock);
         #1;
      end
      tx_ready[2] = 1'b0;
   endtask : drain
   task automatic rx_push(input int n, input logic [7:0] base);
      int j, w;
      for (j = 0; j < n; j++) begin
         check("rx req", rx_dma_request[5], 1'b0);
         rx_data[5] = base + j[7:0];
         rx_valid[5] = 1'b1;
         for (w = 0; w < 50 && rx_ready[5] !== 1'b1; w++) @(negedge clock);
         if (rx_ready[5] !== 1'b1) begin
            check("rx ready", rx_ready[5], 1'b1);
            give_verdict();
         end
         @(posedge clock);
         #1;
      end
      rx_valid[5] = 1'b0;
   endtask : rx_push
   task automatic t_tx;
      int k;
      logic [7:0] b;
      @(posedge clock);
      #1;
      tx_byte_count_high[2] = 8'h00;
      tx_byte_count_low[2] = 8'h28;
      tx_count_load[2] = 1'b1;
      @(posedge clock);
      #1;
      tx_count_load[2] = 1'b0;
      wait_req(1'b1, 2);
      for (k = 0; k < 16; k++) begin
         b = 8'h40 + 8'(2 * k);
         check("tx req", tx_dma_request[2], 1'b1);
         dma_u.access(1'b0, 2, 1'b0, 1'b0, {b + 8'h01, b}, 5 + 3 * (k % 2),
            rd_q);
      end
      repeat (10) @(negedge clock);
      check("tx req", tx_dma_request[2], 1'b0);
      drain(32, 8'h40);
      wait_req(1'b1, 2);
      for (k = 0; k < 8; k++) begin
         b = 8'h60 + 8'(k);
         check("tx req", tx_dma_request[2], 1'b1);
         dma_u.access(1'b0, 2, k[0], 1'b1, k[0] ? {b, ~b} : {~b, b}, 5,
            rd_q);
      end
      drain(8, 8'h60);
      repeat (20) @(negedge clock);
      check("tx req all", tx_dma_request, 8'h00);
   endtask : t_tx
   task automatic t_noack;
      dma_u.access(1'b0, -1, 1'b0, 1'b0, 16'h1234, 5, rd_q);
      dma_u.access(1'b1, -1, 1'b0, 1'b0, 16'h0000, 5, rd_q);
      check("no ack", {tx_valid, rx_dma_request}, 16'h0000);
   endtask : t_noack
   task automatic t_rx;
      int j;
      rx_push(32, 8'h80);
      repeat (3) @(negedge clock);
      check("rx full", rx_ready[5], 1'b0);
      wait_req(1'b0, 5);
      for (j = 0; j < 16; j++) begin
         check("rx req", rx_dma_request[5], 1'b1);
         dma_u.access(1'b1, 5, 1'b0, 1'b0, 16'h0000, 5 + 3 * (j % 2), rd_q);
         check("rx word", rd_q, {8'h81 + 8'(2 * j), 8'h80 + 8'(2 * j)});
      end
      check("rx req", rx_dma_request[5], 1'b0);
      rx_push(2, 8'ha0);
      repeat (10) @(negedge clock);
      check("rx req", rx_dma_request[5], 1'b0);
      dma_u.access(1'b1, 5, 1'b1, 1'b1, 16'h0000, 5, rd_q);
      check("rx byte", rd_q[15:8], 8'ha0);
   endtask : t_rx
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      resetn = 1'b0;
      {tx_count_load, tx_ready, rx_valid} = '0;
      {tx_byte_count_high, tx_byte_count_low, rx_data} = '0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (10) @(posedge clock);
      #1;
      check("reset req", {tx_dma_request, rx_dma_request}, 16'h0000);
      check("reset flow", {tx_valid, rx_ready}, 16'h0000);
      resetn = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check("rx ready", rx_ready, 8'hff);
      t_tx();
      t_noack();
      t_rx();
      give_verdict();
   end
   initial begin
      #2000000;
      check("timeout", 16'h0000, 16'h0001);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
